// [fcp_pkg.sv]
package fcp_pkg;

  // Bus widths and block split
  localparam int ADDR_W       = 16;
  localparam int DATA_W       = 16;
  localparam int BLK_W        = 3;
  localparam int NBLK         = 1 << BLK_W;
  localparam int CMD_W        = 8;
  localparam int RCR_SYNC_BIT = 0;

  // Pin bundle positions inside the control synchroniser
  localparam int CTL_W      = 6;
  localparam int CTL_FRST   = 0;
  localparam int CTL_WP_N   = 1;
  localparam int CTL_ADV_N  = 2;
  localparam int CTL_WE_N   = 3;
  localparam int CTL_VPP_LK = 4;
  localparam int CTL_VCC_LK = 5;

  // Command codes on the low data byte
  localparam logic [CMD_W-1:0] CMD_LOCK_SETUP  = 8'h10;
  localparam logic [CMD_W-1:0] CMD_LOCK        = 8'h11;
  localparam logic [CMD_W-1:0] CMD_UNLOCK      = 8'h12;
  localparam logic [CMD_W-1:0] CMD_LOCKDOWN    = 8'h13;
  localparam logic [CMD_W-1:0] CMD_PROGRAM     = 8'h20;
  localparam logic [CMD_W-1:0] CMD_RCR_SETUP   = 8'h30;
  localparam logic [CMD_W-1:0] CMD_RCR_CONFIRM = 8'h31;

  // Reset values and the burst address step
  localparam logic [NBLK-1:0]   LOCK_RST = 8'hff;
  localparam logic [NBLK-1:0]   DOWN_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;

  typedef enum logic [1:0] {
    FCP_IDLE       = 2'b00,
    FCP_LOCK_SETUP = 2'b01,
    FCP_PROG_SETUP = 2'b11,
    FCP_RCR_SETUP  = 2'b10
  } fcp_cmd_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcp_word_s;

  typedef struct packed {
    fcp_cmd_e          fsm;
    logic [NBLK-1:0]   lock;
    logic [NBLK-1:0]   down;
    logic              sync_mode;
    logic              we_dly;
    logic              ready;
    logic [ADDR_W-1:0] read_addr;
    logic              prog_valid;
    fcp_word_s         prog;
    logic              reject;
    logic              refused;
  } fcp_sys_s;

  typedef struct packed {
    logic [ADDR_W-1:0] burst_addr;
    logic              armed;
    logic              valid;
  } fcp_bus_s;

  localparam fcp_sys_s SYS_RST = '{
    fsm: FCP_IDLE, lock: LOCK_RST, down: DOWN_RST, sync_mode: 1'b0,
    we_dly: 1'b1, ready: 1'b0, read_addr: ADDR_RST, prog_valid: 1'b0,
    prog: '{addr: ADDR_RST, data: DATA_RST}, reject: 1'b0, refused: 1'b0};

  localparam fcp_bus_s BUS_RST = '{burst_addr: ADDR_RST, armed: 1'b1, valid: 1'b0};

endpackage : fcp_pkg

// [fcp_sync2.sv]
`timescale 1ns/100ps
module fcp_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  // Data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= '0;
      o_q      <= '0;
    end else begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule : fcp_sync2

// [fcp_flash_ctrl.sv]
`timescale 1ns/100ps
// Overview of operation
// - Write-protect low: locked-down blocks refuse software unlock commands.
// - Write-protect high: unlock commands also unlock locked-down blocks.
// - Sync reads capture address at first bus clock edge with strobe low.
// - Async reads: address flows through while strobe low, held after rise.
// - Flash reset low holds initial state and refuses every flash operation.
// - Leaving flash reset always returns to asynchronous array-read mode.
// - Program-supply lockout active rejects every array change.
// - Logic-supply lockout active blocks every write cycle.
// - Write address and data are taken at the write-enable rising edge.
// - Sync burst address advances by one on each bus clock with strobe high after the capture edge.
module fcp_flash_ctrl (
  // System clock and reset
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_reset_n,
  // Link bus clock
  input  wire logic                          i_bus_clk,
  // Flash pins
  input  wire logic                          i_flash_rst_n,
  input  wire logic                          i_write_protect_n,
  input  wire logic                          i_address_valid_strobe_n,
  input  wire logic                          i_we_n,
  input  wire logic [fcp_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [fcp_pkg::DATA_W-1:0]    i_data,
  input  wire logic                          i_program_supply_lockout,
  input  wire logic                          i_logic_supply_lockout,
  // System-side status
  output logic                               o_flash_ready,
  output logic                               o_sync_mode,
  output logic [fcp_pkg::ADDR_W-1:0]         o_read_addr,
  output logic [fcp_pkg::NBLK-1:0]           o_lock_state,
  output logic [fcp_pkg::NBLK-1:0]           o_lockdown_state,
  output logic                               o_unlock_refused,
  // Program request
  output logic                               o_prog_valid,
  output fcp_pkg::fcp_word_s                 o_prog,
  output logic                               o_prog_reject,
  // Burst address, bus clock domain
  output logic [fcp_pkg::ADDR_W-1:0]         o_burst_addr,
  output logic                               o_burst_valid
);
  import fcp_pkg::*;

  fcp_sys_s          s_reg;
  fcp_sys_s          s_next;
  fcp_bus_s          b_reg;
  fcp_bus_s          b_next;
  logic [CTL_W-1:0]  ctl_raw;
  logic [CTL_W-1:0]  ctl_s;
  fcp_word_s         word_raw;
  fcp_word_s         word_s;
  logic [1:0]        bus_raw;
  logic [1:0]        bus_s;
  logic              frst_s;
  logic              wp_n_s;
  logic              adv_n_s;
  logic              we_n_s;
  logic              vpp_lk_s;
  logic              vcc_lk_s;
  logic              we_rise;
  logic [BLK_W-1:0]  blk;
  logic [CMD_W-1:0]  cmd;
  logic [NBLK-1:0]   locked_down;
  logic              frst_b;
  logic              mode_b;

  // Pin inputs into the system domain
  assign ctl_raw = {i_logic_supply_lockout, i_program_supply_lockout, i_we_n,
                    i_address_valid_strobe_n, i_write_protect_n, i_flash_rst_n};
  assign word_raw = '{addr: i_addr, data: i_data};

  fcp_sync2 #(.W(CTL_W)) u_ctl_sync (
    .i_clk     (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_d       (ctl_raw),
    .o_q       (ctl_s)
  );

  // Address and data are stable across the write edge, so a plain
  // two-stage sample is enough; a skewed bus would need a handshake.
  fcp_sync2 #(.W(ADDR_W + DATA_W)) u_word_sync (
    .i_clk     (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_d       (word_raw),
    .o_q       (word_s)
  );

  assign frst_s   = ctl_s[CTL_FRST];
  assign wp_n_s   = ctl_s[CTL_WP_N];
  assign adv_n_s  = ctl_s[CTL_ADV_N];
  assign we_n_s   = ctl_s[CTL_WE_N];
  assign vpp_lk_s = ctl_s[CTL_VPP_LK];
  assign vcc_lk_s = ctl_s[CTL_VCC_LK];

  assign we_rise     = we_n_s && !s_reg.we_dly;
  assign blk         = word_s.addr[ADDR_W-1 -: BLK_W];
  assign cmd         = word_s.data[CMD_W-1:0];
  assign locked_down = s_reg.lock & s_reg.down;

  always_comb begin
    s_next            = s_reg;
    s_next.we_dly     = we_n_s;
    s_next.ready      = frst_s;
    s_next.prog_valid = 1'b0;
    s_next.reject     = 1'b0;
    s_next.refused    = 1'b0;
    if (!adv_n_s) begin
      s_next.read_addr = word_s.addr;
    end
    if (we_rise && !vcc_lk_s) begin
      case (s_reg.fsm)
        FCP_IDLE: begin
          case (cmd)
            CMD_LOCK_SETUP: s_next.fsm = FCP_LOCK_SETUP;
            CMD_PROGRAM:    s_next.fsm = FCP_PROG_SETUP;
            CMD_RCR_SETUP:  s_next.fsm = FCP_RCR_SETUP;
            default:        s_next.fsm = FCP_IDLE;
          endcase
        end
        FCP_LOCK_SETUP: begin
          s_next.fsm = FCP_IDLE;
          case (cmd)
            CMD_LOCK: begin
              s_next.lock[blk] = 1'b1;
            end
            CMD_LOCKDOWN: begin
              s_next.lock[blk] = 1'b1;
              s_next.down[blk] = 1'b1;
            end
            CMD_UNLOCK: begin
              if (s_reg.down[blk] && !wp_n_s) begin
                s_next.refused = 1'b1;
              end else begin
                s_next.lock[blk] = 1'b0;
              end
            end
            default: s_next.fsm = FCP_IDLE;
          endcase
        end
        FCP_PROG_SETUP: begin
          s_next.fsm = FCP_IDLE;
          if (vpp_lk_s || s_reg.lock[blk]) begin
            s_next.reject = 1'b1;
          end else begin
            s_next.prog_valid = 1'b1;
            s_next.prog       = word_s;
          end
        end
        FCP_RCR_SETUP: begin
          s_next.fsm = FCP_IDLE;
          if (cmd == CMD_RCR_CONFIRM) begin
            s_next.sync_mode = word_s.addr[RCR_SYNC_BIT];
          end
        end
        default: s_next.fsm = FCP_IDLE;
      endcase
    end
    // Flash reset wins over everything, including a write edge
    if (!frst_s) begin
      s_next = SYS_RST;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_reg <= SYS_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_flash_ready    = s_reg.ready;
  assign o_sync_mode      = s_reg.sync_mode;
  assign o_read_addr      = s_reg.read_addr;
  assign o_lock_state     = s_reg.lock;
  assign o_lockdown_state = s_reg.down;
  assign o_unlock_refused = s_reg.refused;
  assign o_prog_valid     = s_reg.prog_valid;
  assign o_prog           = s_reg.prog;
  assign o_prog_reject    = s_reg.reject;

  // Mode and flash reset are levels, crossed into the bus domain
  assign bus_raw = {s_reg.sync_mode, i_flash_rst_n};

  fcp_sync2 #(.W(2)) u_bus_sync (
    .i_clk     (i_bus_clk),
    .i_reset_n (i_reset_n),
    .i_d       (bus_raw),
    .o_q       (bus_s)
  );

  assign frst_b = bus_s[0];
  assign mode_b = bus_s[1];

  // Strobe and address come from the host on the bus clock itself.
  // A strobe pulse with no bus edge inside it cannot be seen here.
  always_comb begin
    b_next = b_reg;
    if (!frst_b || !mode_b) begin
      b_next = BUS_RST;
    end else if (!i_address_valid_strobe_n && b_reg.armed) begin
      b_next.burst_addr = i_addr;
      b_next.armed      = 1'b0;
      b_next.valid      = 1'b1;
    end else if (i_address_valid_strobe_n) begin
      b_next.armed = 1'b1;
      if (b_reg.valid) begin
        b_next.burst_addr = b_reg.burst_addr + ADDR_ONE;
      end
    end
  end

  always_ff @(posedge i_bus_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      b_reg <= BUS_RST;
    end else begin
      b_reg <= b_next;
    end
  end

  assign o_burst_addr  = b_reg.burst_addr;
  assign o_burst_valid = b_reg.valid;

  sequence unlock_cmd_s;
    we_rise && !vcc_lk_s && s_reg.fsm == FCP_LOCK_SETUP && cmd == CMD_UNLOCK;
  endsequence

  sequence prog_cmd_s;
    we_rise && !vcc_lk_s && s_reg.fsm == FCP_PROG_SETUP;
  endsequence

  lockdown_hold_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n || !frst_s)
    !wp_n_s |=> ((s_reg.lock & $past(locked_down)) == $past(locked_down)))
    else $error("locked-down block was unlocked while protected");

  unlock_allow_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n || !frst_s)
    (unlock_cmd_s and wp_n_s) |=> !s_reg.lock[$past(blk)])
    else $error("unlock with protect high did not clear lock");

  refuse_flag_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n || !frst_s)
    (unlock_cmd_s and (!wp_n_s && s_reg.down[blk])) |=> s_reg.refused && s_reg.lock[$past(blk)])
    else $error("protected unlock not refused");

  async_pass_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n || !frst_s)
    !adv_n_s |=> o_read_addr == $past(word_s.addr))
    else $error("address did not flow through with strobe low");

  async_hold_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n || !frst_s)
    adv_n_s [*2] |-> $stable(o_read_addr))
    else $error("latched address changed with strobe high");

  reset_hold_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    !frst_s |=> (s_reg.fsm == FCP_IDLE && !o_prog_valid && !o_flash_ready))
    else $error("flash operation while flash reset low");

  reset_mode_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    $rose(frst_s) |-> !o_sync_mode ##1 !o_sync_mode)
    else $error("reset exit not in asynchronous mode");

  vpp_reject_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n || !frst_s)
    (prog_cmd_s and vpp_lk_s) |=> (o_prog_reject && !o_prog_valid))
    else $error("program accepted under supply lockout");

  vcc_block_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n || !frst_s)
    (vcc_lk_s && s_reg.fsm == FCP_IDLE) |=> (s_reg.fsm == FCP_IDLE && !o_prog_valid))
    else $error("write taken under logic lockout");

  prog_take_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n || !frst_s)
    (prog_cmd_s and (!vpp_lk_s && !s_reg.lock[blk])) |=> o_prog_valid && o_prog == $past(word_s))
    else $error("program word not taken at write edge");

  burst_cap_a: assert property (
    @(posedge i_bus_clk) disable iff (!i_reset_n || !frst_b || !mode_b)
    (!i_address_valid_strobe_n && b_reg.armed) |=> o_burst_addr == $past(i_addr) && o_burst_valid)
    else $error("burst start address not captured");

  burst_step_a: assert property (
    @(posedge i_bus_clk) disable iff (!i_reset_n || !frst_b || !mode_b)
    (i_address_valid_strobe_n && b_reg.valid) |=> o_burst_addr == $past(o_burst_addr) + ADDR_ONE)
    else $error("burst address did not advance by one");

  reset_init_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    !frst_s |=> (o_lock_state == LOCK_RST && o_lockdown_state == DOWN_RST && !o_sync_mode))
    else $error("flash reset did not restore initial state");

  vcc_state_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n || !frst_s)
    vcc_lk_s |=> ($stable(s_reg.fsm) && $stable(o_lock_state) && $stable(o_sync_mode)
                  && !o_prog_valid))
    else $error("state changed under logic lockout");

endmodule : fcp_flash_ctrl

// [fcp_host_model.sv]
`timescale 1ns/100ps
module fcp_host_model (
  // Clock
  input  wire logic                       i_sys_clk,
  // Flash bus pins
  output logic                            o_bus_clk,
  output logic                            o_strobe_n,
  output logic                            o_we_n,
  output logic [fcp_pkg::ADDR_W-1:0]      o_addr,
  output logic [fcp_pkg::DATA_W-1:0]      o_data
);
  import fcp_pkg::*;

  initial begin
    o_bus_clk  = 1'b0;
    o_strobe_n = 1'b1;
    o_we_n     = 1'b1;
    o_addr     = ADDR_RST;
    o_data     = DATA_RST;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_data <= d;
    repeat (3) @(posedge i_sys_clk);
    o_we_n <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    o_we_n <= 1'b1; // Word stays put across the rise
    repeat (4) @(posedge i_sys_clk);
    // Released bus shows the inverse so a stale word cannot pass
    o_addr <= ~a;
    o_data <= ~d;
    repeat (4) @(posedge i_sys_clk);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge i_sys_clk);
    o_addr     <= a;
    o_strobe_n <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    o_strobe_n <= 1'b1; // Strobe high outside address phases
    repeat (4) @(posedge i_sys_clk);
    o_addr <= ~a;
    repeat (6) @(posedge i_sys_clk);
  endtask : rd

  // Link clock runs only inside a frame
  task automatic bclk_cycle();
    #32 o_bus_clk = 1'b1;
    #32 o_bus_clk = 1'b0;
  endtask : bclk_cycle

  task automatic burst(input logic [ADDR_W-1:0] a, input int n);
    #7;
    // Preamble lets the mode bit cross into the bus domain
    repeat (4) bclk_cycle();
    o_addr     = a;
    o_strobe_n = 1'b0;
    bclk_cycle();
    o_strobe_n = 1'b1;
    o_addr     = ~a;
    // Capture edge is spent above; each edge from here adds one
    repeat (n) bclk_cycle();
  endtask : burst
endmodule : fcp_host_model

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import fcp_pkg::*;

  logic              i_sys_clk;
  logic              i_reset_n;
  logic              frst_n;
  logic              wp_n;
  logic              vpp_lk;
  logic              vcc_lk;
  logic              bus_clk;
  logic              strobe_n;
  logic              we_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  logic              ready;
  logic              sync_mode;
  logic [ADDR_W-1:0] read_addr;
  logic [NBLK-1:0]   lock;
  logic [NBLK-1:0]   down;
  logic              refused;
  logic              prog_valid;
  fcp_word_s         prog;
  logic              reject;
  logic [ADDR_W-1:0] burst_addr;
  logic              burst_valid;
  int                fail_count;
  int                n_compared;
  int                cycles;
  int                n_valid;
  int                n_rej;
  int                n_ref;

  fcp_host_model host_u (.i_sys_clk(i_sys_clk), .o_bus_clk(bus_clk), .o_strobe_n(strobe_n),
    .o_we_n(we_n), .o_addr(addr), .o_data(data));

  fcp_flash_ctrl dut_u (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_bus_clk(bus_clk),
    .i_flash_rst_n(frst_n), .i_write_protect_n(wp_n), .i_address_valid_strobe_n(strobe_n),
    .i_we_n(we_n), .i_addr(addr), .i_data(data), .i_program_supply_lockout(vpp_lk),
    .i_logic_supply_lockout(vcc_lk), .o_flash_ready(ready), .o_sync_mode(sync_mode),
    .o_read_addr(read_addr), .o_lock_state(lock), .o_lockdown_state(down),
    .o_unlock_refused(refused), .o_prog_valid(prog_valid), .o_prog(prog),
    .o_prog_reject(reject), .o_burst_addr(burst_addr), .o_burst_valid(burst_valid));

  initial i_sys_clk = 1'b0;
  always #12.5 i_sys_clk = ~i_sys_clk;

  task automatic tally_and_finish();
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // One-cycle pulses are counted where they stand
  always @(posedge i_sys_clk) begin
    cycles++;
    if (prog_valid === 1'b1) n_valid++;
    if (reject === 1'b1) n_rej++;
    if (refused === 1'b1) n_ref++;
    if (cycles == 6000) begin
      $display("CHECK FAILED t=%0t run did not finish in time", $time);
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic cmd2(input logic [15:0] a, input logic [7:0] op, input logic [15:0] d2);
    host_u.wr(a, {8'h00, op});
    host_u.wr(a, d2);
  endtask : cmd2

  task automatic t_reset();
    chk(ready, 1, "ready");
    chk(sync_mode, 0, "async mode");
    chk(lock, LOCK_RST, "lock reset");
    chk(down, DOWN_RST, "lockdown reset");
  endtask : t_reset

  task automatic t_async();
    host_u.rd(16'h1234);
    chk(read_addr, 16'h1234, "async latch");
  endtask : t_async

  task automatic t_lock();
    cmd2(16'h2000, CMD_LOCK_SETUP, {8'h00, CMD_UNLOCK});
    chk(lock[1], 0, "unlock");
    cmd2(16'h4000, CMD_LOCK_SETUP, {8'h00, CMD_LOCKDOWN});
    chk(down[2], 1, "lockdown");
    @(posedge i_sys_clk) wp_n <= 1'b0;
    n_ref = 0;
    cmd2(16'h4000, CMD_LOCK_SETUP, {8'h00, CMD_UNLOCK});
    chk(lock[2], 1, "held locked");
    chk(n_ref, 1, "refusal pulse");
    @(posedge i_sys_clk) wp_n <= 1'b1;
    cmd2(16'h4000, CMD_LOCK_SETUP, {8'h00, CMD_UNLOCK});
    chk(lock[2], 0, "lockdown overridden");
    chk(n_ref, 1, "no refusal");
    cmd2(16'h2000, CMD_LOCK_SETUP, {8'h00, CMD_LOCK});
    chk(lock[1], 1, "relock");
  endtask : t_lock

  task automatic t_prog();
    n_valid = 0;
    n_rej   = 0;
    cmd2(16'h4abc, CMD_PROGRAM, 16'h1234);
    chk(n_valid, 1, "program pulse");
    chk(prog, 32'h4abc1234, "program word");
    @(posedge i_sys_clk) vpp_lk <= 1'b1;
    cmd2(16'h4002, CMD_PROGRAM, 16'h5555);
    chk(n_rej, 1, "supply reject");
    chk(n_valid, 1, "no program");
    @(posedge i_sys_clk) vpp_lk <= 1'b0;
    vcc_lk <= 1'b1;
    cmd2(16'h4004, CMD_PROGRAM, 16'h6666);
    cmd2(16'h4000, CMD_LOCK_SETUP, {8'h00, CMD_LOCK});
    chk(n_valid + n_rej, 2, "writes ignored");
    chk(lock[2], 0, "lock ignored");
    @(posedge i_sys_clk) vcc_lk <= 1'b0;
  endtask : t_prog

  task automatic t_sync();
    cmd2(16'h0001, CMD_RCR_SETUP, {8'h00, CMD_RCR_CONFIRM});
    chk(sync_mode, 1, "sync mode");
    host_u.burst(16'h0100, 5);
    chk(burst_valid, 1, "burst capture");
    chk(burst_addr, 16'h0105, "burst advance");
    @(posedge i_sys_clk) frst_n <= 1'b0;
    n_valid = 0;
    n_rej   = 0;
    cmd2(16'h4000, CMD_PROGRAM, 16'h7777);
    chk(n_valid + n_rej, 0, "refused in reset");
    chk(ready, 0, "not ready");
    chk(lock, LOCK_RST, "locks restored");
    @(posedge i_sys_clk) frst_n <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    chk(ready, 1, "ready again");
    chk(sync_mode, 0, "async after reset");
  endtask : t_sync

  initial begin
    i_reset_n  = 1'b0;
    frst_n     = 1'b1;
    wp_n       = 1'b1;
    vpp_lk     = 1'b0;
    vcc_lk     = 1'b0;
    fail_count = 0;
    n_compared = 0;
    cycles     = 0;
    repeat (4) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    t_reset();
    t_async();
    t_lock();
    t_prog();
    t_sync();
    tally_and_finish();
  end
endmodule : tb_top
